// [flash_guard_pkg.sv]
package flash_guard_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] FLASH_LOCK_KEY_ADDR   = 8'hB7;
   localparam logic [7:0] PROG_STORE_CTRL_ADDR  = 8'h8F;
   localparam logic [7:0] FLASH_LOCK_KEY_RESET  = 8'h00;
   localparam logic [7:0] PROG_STORE_CTRL_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Field positions and key values
   // ----------------------------------------------------------------
   localparam int         WRITE_ENABLE_BIT = 0;
   localparam int         ERASE_ENABLE_BIT = 1;
   localparam logic [7:0] KEY_FIRST        = 8'hA5;
   localparam logic [7:0] KEY_SECOND       = 8'hF1;

   // Reported lock codes
   localparam logic [1:0] CODE_LOCKED   = 2'h0;
   localparam logic [1:0] CODE_FIRST    = 2'h1;
   localparam logic [1:0] CODE_UNLOCKED = 2'h2;
   localparam logic [1:0] CODE_DISABLED = 2'h3;

   typedef enum logic [1:0] {
      LOCK_IDLE,
      LOCK_FIRST,
      LOCK_OPEN,
      LOCK_DEAD
   } lock_state_t;

endpackage

// [flash_op_issue.sv]
`timescale 1ns/1ps

// Turns one accepted store into a registered flash command pulse
module flash_op_issue
   import flash_guard_pkg::*;
#(
   parameter int ADDR_W = 13
)
(
   input  wire logic              sys_clk,
   input  wire logic              rst_b,
   input  wire logic              go,
   input  wire logic              erase,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [7:0]        data,
   output logic                   wr_stb,
   output logic                   er_stb,
   output logic [ADDR_W-1:0]      addr_q,
   output logic [7:0]             data_q
);

   logic              wr_reg, wr_next;
   logic              er_reg, er_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic [7:0]        data_reg, data_next;

   // Erase ignores the data byte, so data is held only for writes
   always_comb
   begin
      wr_next   = go && !erase;
      er_next   = go && erase;
      addr_next = go ? addr : addr_reg;
      data_next = (go && !erase) ? data : data_reg;
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wr_reg   <= 1'b0;
         er_reg   <= 1'b0;
         addr_reg <= '0;
         data_reg <= 8'h00;
      end
      else
      begin
         wr_reg   <= wr_next;
         er_reg   <= er_next;
         addr_reg <= addr_next;
         data_reg <= data_next;
      end
   end

   assign wr_stb = wr_reg;
   assign er_stb = er_reg;
   assign addr_q = addr_reg;
   assign data_q = data_reg;

endmodule

// [flash_lock_key_guard.sv]
`timescale 1ns/1ps

module flash_lock_key_guard
   import flash_guard_pkg::*;
#(
   parameter int ADDR_W = 13
)
(
   input  wire logic              sys_clk,
   input  wire logic              rst_b,
   // Special register port
   input  wire logic              sfr_wr,
   input  wire logic              sfr_rd,
   input  wire logic [7:0]        sfr_addr,
   input  wire logic [7:0]        sfr_wdata,
   output logic [7:0]             sfr_rdata,
   // Data-memory store port from the core
   input  wire logic              store_req,
   input  wire logic [ADDR_W-1:0] store_addr,
   input  wire logic [7:0]        store_data,
   output logic                   xram_store,
   // Flash array command and completion
   output logic                   flash_write,
   output logic                   flash_erase,
   output logic [ADDR_W-1:0]      flash_addr,
   output logic [7:0]             flash_wdata,
   input  wire logic              flash_done,
   // Current lock code
   output logic [1:0]             lock_state
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   if (ADDR_W < 1 || ADDR_W > 16)
   begin : g_bad_width
      $error("ADDR_W must be 1 to 16");
   end

   // ----------------------------------------------------------------
   // Control register and lock state
   // ----------------------------------------------------------------
   lock_state_t lock_reg, lock_next;
   logic        write_en_reg, write_en_next;
   logic        erase_en_reg, erase_en_next;
   logic        busy_reg, busy_next;
   logic [7:0]  rdata_reg, rdata_next;
   logic        xram_reg, xram_next;
   logic        key_wr, ctrl_wr, flash_store, go;
   logic [1:0]  code;

   assign key_wr      = sfr_wr && (sfr_addr == FLASH_LOCK_KEY_ADDR);
   assign ctrl_wr     = sfr_wr && (sfr_addr == PROG_STORE_CTRL_ADDR);
   assign flash_store = store_req && write_en_reg;
   assign go          = flash_store && (lock_reg == LOCK_OPEN) && !busy_reg;

   // Lock code as seen by software
   always_comb
   begin
      case (lock_reg)
         LOCK_IDLE:  code = CODE_LOCKED;
         LOCK_FIRST: code = CODE_FIRST;
         LOCK_OPEN:  code = CODE_UNLOCKED;
         LOCK_DEAD:  code = CODE_DISABLED;
         default:    code = CODE_DISABLED;
      endcase
   end

   // Key sequence, relock and permanent lock
   always_comb
   begin
      lock_next = lock_reg;
      case (lock_reg)
         LOCK_IDLE:
         begin
            if (flash_store)
               lock_next = LOCK_DEAD;
            else if (key_wr && sfr_wdata == KEY_FIRST)
               lock_next = LOCK_FIRST;
            else if (key_wr)
               lock_next = LOCK_DEAD;
         end
         LOCK_FIRST:
         begin
            if (flash_store)
               lock_next = LOCK_DEAD;
            else if (key_wr && sfr_wdata == KEY_SECOND)
               lock_next = LOCK_OPEN;
            else if (key_wr)
               lock_next = LOCK_DEAD;
         end
         LOCK_OPEN:
         begin
            // A key write while open breaks the sequence
            if (key_wr)
               lock_next = LOCK_DEAD;
            else if (busy_reg && flash_done)
               lock_next = LOCK_IDLE;
         end
         LOCK_DEAD:
            lock_next = LOCK_DEAD;
         default:
            lock_next = LOCK_DEAD;
      endcase
   end

   // One operation in flight; a second store while busy is dropped
   always_comb
   begin
      busy_next = busy_reg;
      if (go)
         busy_next = 1'b1;
      else if (flash_done)
         busy_next = 1'b0;
      write_en_next = write_en_reg;
      erase_en_next = erase_en_reg;
      if (ctrl_wr)
      begin
         write_en_next = sfr_wdata[WRITE_ENABLE_BIT];
         erase_en_next = sfr_wdata[ERASE_ENABLE_BIT];
      end
      // Stores with write enable clear never reach flash
      xram_next = store_req && !write_en_reg;
   end

   // Registered read data; reserved bits read zero
   always_comb
   begin
      rdata_next = 8'h00;
      if (sfr_rd && sfr_addr == FLASH_LOCK_KEY_ADDR)
         rdata_next = {6'h00, code};
      else if (sfr_rd && sfr_addr == PROG_STORE_CTRL_ADDR)
         rdata_next = {6'h00, erase_en_reg, write_en_reg};
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lock_reg     <= LOCK_IDLE;
         write_en_reg <= PROG_STORE_CTRL_RESET[WRITE_ENABLE_BIT];
         erase_en_reg <= PROG_STORE_CTRL_RESET[ERASE_ENABLE_BIT];
         busy_reg     <= 1'b0;
         rdata_reg    <= FLASH_LOCK_KEY_RESET;
         xram_reg     <= 1'b0;
      end
      else
      begin
         lock_reg     <= lock_next;
         write_en_reg <= write_en_next;
         erase_en_reg <= erase_en_next;
         busy_reg     <= busy_next;
         rdata_reg    <= rdata_next;
         xram_reg     <= xram_next;
      end
   end

   // ----------------------------------------------------------------
   // Flash command issue
   // ----------------------------------------------------------------
   flash_op_issue #(
      .ADDR_W (ADDR_W)
   ) u_issue (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .go      (go),
      .erase   (erase_en_reg),
      .addr    (store_addr),
      .data    (store_data),
      .wr_stb  (flash_write),
      .er_stb  (flash_erase),
      .addr_q  (flash_addr),
      .data_q  (flash_wdata)
   );

   // Code is taken from the next state so lock_state never lags lock_reg
   logic [1:0] code_reg, code_next;
   always_comb
   begin
      code_next = code_of(lock_next);
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         code_reg <= CODE_LOCKED;
      else
         code_reg <= code_next;
   end

   function automatic logic [1:0] code_of(input lock_state_t s);
      case (s)
         LOCK_IDLE:  code_of = CODE_LOCKED;
         LOCK_FIRST: code_of = CODE_FIRST;
         LOCK_OPEN:  code_of = CODE_UNLOCKED;
         default:    code_of = CODE_DISABLED;
      endcase
   endfunction

   assign sfr_rdata  = rdata_reg;
   assign xram_store = xram_reg;
   assign lock_state = code_reg;

endmodule

// [flash_lock_key_guard_asserts.sv]
`timescale 1ns/1ps
// ----------
// Guard port checker
// ----------
module flash_lock_key_guard_asserts
(
   input wire logic       sys_clk,
   input wire logic       rst_b,
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic       store_req,
   input wire logic       flash_write,
   input wire logic       flash_erase,
   input wire logic       flash_done,
   input wire logic [1:0] lock_state
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // Key writes; a flash store in the same cycle takes priority before the key sequence is open, so leave it out
   wire key_wr = sfr_wr && sfr_addr == 8'hB7 && !store_req;
   wire strobe = flash_write || flash_erase;
   AST_FIRST: assert property (
      key_wr && sfr_wdata == 8'hA5 && lock_state == 2'h0 |=> lock_state == 2'h1)
      else $error("first key ignored");
   AST_SECOND: assert property (
      key_wr && sfr_wdata == 8'hF1 && lock_state == 2'h1 |=> lock_state == 2'h2)
      else $error("second key ignored");
   AST_BAD_KEY: assert property (
      key_wr && (lock_state[1] || sfr_wdata != (lock_state[0] ? 8'hF1 : 8'hA5))
      |=> lock_state == 2'h3) else $error("bad key left flash open");
   AST_DEAD: assert property (lock_state == 2'h3 |=> lock_state == 2'h3)
      else $error("lock left disabled state");
   AST_RELOCK: assert property (
      lock_state == 2'h2 && flash_done && !sfr_wr && !store_req |=> lock_state == 2'h0)
      else $error("no relock after operation");
   AST_GATE: assert property (strobe |-> lock_state == 2'h2)
      else $error("flash command while locked");
   AST_ISSUE: assert property (
      strobe |-> $past(store_req) && !(flash_write && flash_erase))
      else $error("stray flash command");
   AST_READ: assert property (
      sfr_rd && sfr_addr == 8'hB7 && !sfr_wr && !store_req && !flash_done
      |=> sfr_rdata == {6'h00, $past(lock_state)}) else $error("key read wrong");
   cover property (key_wr && lock_state == 2'h1 && sfr_wdata == 8'hF1);
   cover property (flash_erase);
   cover property (lock_state == 2'h2 && flash_done);
endmodule

bind flash_lock_key_guard flash_lock_key_guard_asserts u_asserts (
   .sys_clk     (sys_clk),
   .rst_b       (rst_b),
   .sfr_wr      (sfr_wr),
   .sfr_rd      (sfr_rd),
   .sfr_addr    (sfr_addr),
   .sfr_wdata   (sfr_wdata),
   .sfr_rdata   (sfr_rdata),
   .store_req   (store_req),
   .flash_write (flash_write),
   .flash_erase (flash_erase),
   .flash_done  (flash_done),
   .lock_state  (lock_state)
);

// [flash_array_model.sv]
`timescale 1ns/1ps
// ----------
// Flash array model
// ----------
module flash_array_model
(
   input wire logic       sys_clk,
   input wire logic       rst_b,
   input wire logic       flash_write,
   input wire logic       flash_erase,
   input wire logic [3:0] lat,
   output logic           flash_done
);
   logic [3:0] cnt_reg;
   // Busy countdown; a slow array is simply a larger lat
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         cnt_reg <= 4'h0;
      else if (flash_write || flash_erase)
         cnt_reg <= lat + 4'h1;
      else if (cnt_reg != 4'h0)
         cnt_reg <= cnt_reg - 4'h1;
   end
   // Completion pulse stands one cycle
   assign flash_done = (cnt_reg == 4'h1);
endmodule

// [flash_lock_key_guard_tb_top.sv]
`timescale 1ns/1ps
// ----------
// Guard testbench
// ----------
module flash_lock_key_guard_tb_top;
   localparam int AW = 13;
   logic          sys_clk = 1'b0, rst_b = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, store_req = 1'b0;
   logic [7:0]    sfr_addr = 8'h00, sfr_wdata = 8'h00, store_data = 8'h00, sfr_rdata, flash_wdata;
   logic [AW-1:0] store_addr = '0, flash_addr;
   logic          xram_store, flash_write, flash_erase, flash_done;
   logic [1:0]    lock_state;
   logic [3:0]    lat = 4'h1;
   int            fail_count = 0, compares = 0;
   // Clock, design and flash model
   initial forever #5 sys_clk = ~sys_clk;
   flash_lock_key_guard #(.ADDR_W(AW)) dut (
      .sys_clk     (sys_clk),
      .rst_b       (rst_b),
      .sfr_wr      (sfr_wr),
      .sfr_rd      (sfr_rd),
      .sfr_addr    (sfr_addr),
      .sfr_wdata   (sfr_wdata),
      .sfr_rdata   (sfr_rdata),
      .store_req   (store_req),
      .store_addr  (store_addr),
      .store_data  (store_data),
      .xram_store  (xram_store),
      .flash_write (flash_write),
      .flash_erase (flash_erase),
      .flash_addr  (flash_addr),
      .flash_wdata (flash_wdata),
      .flash_done  (flash_done),
      .lock_state  (lock_state)
   );
   flash_array_model flash (
      .sys_clk     (sys_clk),
      .rst_b       (rst_b),
      .flash_write (flash_write),
      .flash_erase (flash_erase),
      .lat         (lat),
      .flash_done  (flash_done)
   );
   // Scoring and run control
   task automatic chk(input string n, input logic [23:0] s, input logic [23:0] x);
      compares++;
      fail_count += int'(s !== x);
      if (s !== x) $display("mismatch %s expected %h seen %h", n, x, s);
   endtask
   task automatic print_verdict();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   function automatic logic [1:0] next_code(input logic [1:0] c, input logic [7:0] k);
      if (c == 2'h0 && k == 8'hA5) return 2'h1;
      if (c == 2'h1 && k == 8'hF1) return 2'h2;
      return 2'h3;
   endfunction
   // Bus drivers; an idle cycle follows each strobe so none is re-raised at once
   task automatic rst();
      rst_b = 1'b0;
      repeat (8) @(posedge sys_clk);
      #1 rst_b = 1'b1;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {w, !w, a, d};
      @(posedge sys_clk) #1 {sfr_wr, sfr_rd} = 2'b00;
      if (!w) chk("rdata", sfr_rdata, d);
      @(posedge sys_clk) #1;
   endtask
   task automatic st(input logic [2:0] s);
      {store_addr, store_data} = (AW+8)'($urandom);
      store_req = 1'b1;
      @(posedge sys_clk) #1 store_req = 1'b0;
      chk("strobes", {xram_store, flash_write, flash_erase}, s);
      if (s[1]) chk("target", {flash_addr, flash_wdata}, {store_addr, store_data});
      if (s[0]) chk("page", flash_addr, store_addr);
      @(posedge sys_clk) #1;
   endtask
   // Random key sequences, one store, then the locked and data-memory paths
   initial
   begin
      logic [1:0] want;
      logic [7:0] k;
      logic       er;
      int         i;
      void'($urandom(45100));
      rst();
      bus(1'b0, 8'h55, 8'h00);
      repeat (60)
      begin
         rst();
         bus(1'b0, 8'hB7, 8'h00);
         want = 2'h0;
         repeat ($urandom_range(1, 3))
         begin
            k = ($urandom_range(0, 3) == 0) ? 8'($urandom) : (want == 2'h0 ? 8'hA5 : 8'hF1);
            bus(1'b1, 8'hB7, k);
            want = next_code(want, k);
            bus(1'b0, 8'hB7, {6'h00, want});
            chk("lock_state", lock_state, want);
         end
         er = 1'($urandom);
         lat = 4'($urandom_range(1, 6));
         bus(1'b1, 8'h8F, {6'h00, er, 1'b1});
         bus(1'b0, 8'h8F, {6'h00, er, 1'b1});
         st({1'b0, want == 2'h2 && !er, want == 2'h2 && er});
         for (i = 0; want == 2'h2 && i < 20 && flash_done !== 1'b1; i++)
            @(posedge sys_clk) #1;
         @(posedge sys_clk) #1;
         bus(1'b0, 8'hB7, want == 2'h2 ? 8'h00 : 8'h03);
         st(3'b000);
         bus(1'b0, 8'hB7, 8'h03);
         bus(1'b1, 8'h8F, 8'h00);
         st(3'b100);
      end
      print_verdict();
   end
   // Watchdog well beyond the expected run time
   initial
   begin
      #100000;
      fail_count++;
      print_verdict();
   end
endmodule
